// >>> igf_file_store.sv
`timescale 1ns/1ps
// Functional notes
// - content request opens session or answers unknown
// - open states name, count; then records, close
// - record count must be 1 to 99
// - record outside open session is error
// - record holds one group, 8-60 characters
// - close outside open session is rejected
// - opener closes only after all records
// - delete removes file and deselects it
// - delete of unknown name answers unknown
// - reselecting a selected file changes nothing
// - select of missing file answers unknown
// - lacking capacity answers capacity error
// - faulty file content answers content error
// - deselect stops broadcasting the named file
// - deselect of unselected file answers unknown
// - error during session aborts, no file
// - session errors: count, used, no store
// - select errors: unknown, capacity, content
// - names up to 16 chars, compared exactly
// - new file needs an unused name
// - broadcast selected groups; reconfig clears selections
module igf_file_store
  import igf_pkg::*;
#(
  parameter int unsigned SLOTS = DEF_SLOTS,
  parameter int unsigned RECORDS = DEF_RECORDS,
  parameter int unsigned CAPACITY = DEF_CAPACITY
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  input wire igf_msg_type in_msg,
  output logic in_ready,
  output logic out_valid,
  output igf_out_type out_msg,
  input wire logic out_ready,
  output logic bc_valid,
  output logic [GROUP_W-1:0] bc_group,
  output logic [BLEN_W-1:0] bc_group_len,
  input wire logic bc_ready,
  output logic [SLOTS-1:0] slot_sel
);

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned SW = $clog2(SLOTS);
  localparam int unsigned DEPTH = SLOTS * RECORDS;
  localparam int unsigned AW = $clog2(DEPTH);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [SLOTS-1:0] slot_used; // store holds a file
  logic [SLOTS-1:0] slot_bad; // file has malformed groups
  logic [NAME_W-1:0] slot_name [SLOTS];
  logic [LEN_W-1:0] slot_nlen [SLOTS];
  logic [CNT_W-1:0] slot_cnt [SLOTS];
  logic [GROUP_W-1:0] grp_mem [DEPTH]; // groups, slot-major
  logic [BLEN_W-1:0] grp_len [DEPTH];

  // session tracking
  igf_state_type state;
  logic [SW-1:0] rx_slot; // store being filled
  logic [CNT_W-1:0] rx_cnt; // declared records
  logic [CNT_W-1:0] rx_idx; // records taken so far
  logic rx_bad; // a malformed group was seen
  logic [NAME_W-1:0] rx_name;
  logic [LEN_W-1:0] rx_nlen;
  logic [SW-1:0] tx_slot; // store being sent out
  logic [CNT_W-1:0] tx_idx; // next record to send

  // broadcast scan
  logic [SW-1:0] bc_slot;
  logic [CNT_W-1:0] bc_rec;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  logic acc; // message taken this edge
  logic hit; // named file exists
  logic [SW-1:0] hit_idx;
  logic free_any; // a store is free
  logic [SW-1:0] free_idx;
  logic [15:0] sel_load; // groups already on air
  logic grp_ok; // group length in range

  assign acc = ce && in_valid && in_ready;
  assign grp_ok = (in_msg.group_len >= BLEN_W'(GROUP_MIN_BYTES))
               && (in_msg.group_len <= BLEN_W'(GROUP_MAX_BYTES));

  // names matched in full, length included
  igf_name_match #(.SLOTS(SLOTS), .IW(SW)) u_match (
    .used(slot_used),
    .names(slot_name),
    .lens(slot_nlen),
    .key(in_msg.name),
    .key_len(in_msg.name_len),
    .hit(hit),
    .hit_idx(hit_idx),
    .free_any(free_any),
    .free_idx(free_idx)
  );

  // total groups of selected files
  always_comb begin
    sel_load = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (slot_sel[i]) begin
        sel_load = sel_load + 16'(slot_cnt[i]);
      end
    end
  end

  function automatic logic [AW-1:0] mem_addr(logic [SW-1:0] s, logic [CNT_W-1:0] r);
    mem_addr = AW'(int'(s) * int'(RECORDS) + int'(r));
  endfunction

  function automatic igf_out_type make_out(igf_out_kind_type k, logic [NAME_W-1:0] n,
      logic [LEN_W-1:0] l, logic [CAUSE_W-1:0] c);
    make_out = '0;
    make_out.kind = k;
    make_out.name = n;
    make_out.name_len = l;
    make_out.cause = c;
  endfunction

  // ----------------------------------------
  // message handling
  // ----------------------------------------
  // one message at a time; any error raised in a session ends it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      slot_used <= '0;
      slot_bad <= '0;
      slot_sel <= '0;
      rx_slot <= '0;
      rx_cnt <= '0;
      rx_idx <= '0;
      rx_bad <= 1'b0;
      rx_name <= '0;
      rx_nlen <= '0;
      tx_slot <= '0;
      tx_idx <= '0;
      out_valid <= 1'b0;
      out_msg <= '0;
    end else if (ce) begin
      // answer drained by the far side
      if (out_valid && out_ready) begin
        out_valid <= 1'b0;
      end
      if (acc) begin
        case (in_msg.op)
          OP_CONTENT_REQUEST: begin
            if (hit) begin
              state <= ST_TX;
              tx_slot <= hit_idx;
              tx_idx <= '0;
              out_valid <= 1'b1;
              out_msg <= make_out(OUT_OPEN, in_msg.name, in_msg.name_len, '0);
              out_msg.record_count <= slot_cnt[hit_idx];
            end else begin
              state <= ST_IDLE;
              out_valid <= 1'b1;
              out_msg <= make_out(OUT_ERROR, in_msg.name, in_msg.name_len, CAUSE_UNKNOWN);
            end
          end
          OP_SESSION_OPEN: begin
            out_valid <= 1'b1;
            state <= ST_IDLE;
            if (state == ST_RX) begin // second open aborts the first
              out_msg <= make_out(OUT_ERROR, rx_name, rx_nlen, WRONG_RECORD_COUNT_CAUSE);
            end else if (hit) begin
              out_msg <= make_out(OUT_ERROR, in_msg.name, in_msg.name_len, CAUSE_USED);
            end else if (!free_any) begin
              out_msg <= make_out(OUT_ERROR, in_msg.name, in_msg.name_len,
                                  NO_FREE_STORE_CAUSE);
            end else if ((in_msg.record_count < CNT_W'(MIN_RECORDS))
                      || (in_msg.record_count > CNT_W'(RECORDS))) begin
              out_msg <= make_out(OUT_ERROR, in_msg.name, in_msg.name_len,
                                  WRONG_RECORD_COUNT_CAUSE);
            end else begin
              out_valid <= 1'b0;
              state <= ST_RX;
              rx_slot <= free_idx;
              rx_cnt <= in_msg.record_count;
              rx_idx <= '0;
              rx_bad <= 1'b0;
              rx_name <= in_msg.name;
              rx_nlen <= in_msg.name_len;
            end
          end
          OP_RECORD: begin
            if (state != ST_RX) begin
              out_valid <= 1'b1;
              out_msg <= make_out(OUT_ERROR, '0, '0, WRONG_RECORD_COUNT_CAUSE);
            end else if (rx_idx == rx_cnt) begin // too many records
              state <= ST_IDLE;
              out_valid <= 1'b1;
              out_msg <= make_out(OUT_ERROR, rx_name, rx_nlen, WRONG_RECORD_COUNT_CAUSE);
            end else begin
              grp_mem[mem_addr(rx_slot, rx_idx)] <= in_msg.group;
              grp_len[mem_addr(rx_slot, rx_idx)] <= in_msg.group_len;
              rx_idx <= rx_idx + 1'b1;
              rx_bad <= rx_bad || !grp_ok;
            end
          end
          OP_SESSION_CLOSE: begin
            if (state != ST_RX) begin
              out_valid <= 1'b1;
              out_msg <= make_out(OUT_ERROR, '0, '0, WRONG_RECORD_COUNT_CAUSE);
            end else if (rx_idx != rx_cnt) begin
              state <= ST_IDLE;
              out_valid <= 1'b1;
              out_msg <= make_out(OUT_ERROR, rx_name, rx_nlen, WRONG_RECORD_COUNT_CAUSE);
            end else begin // file becomes visible only now
              state <= ST_IDLE;
              slot_used[rx_slot] <= 1'b1;
              slot_bad[rx_slot] <= rx_bad;
              slot_name[rx_slot] <= rx_name;
              slot_nlen[rx_slot] <= rx_nlen;
              slot_cnt[rx_slot] <= rx_cnt;
            end
          end
          OP_DELETE: begin
            if (hit) begin
              slot_used[hit_idx] <= 1'b0;
              slot_sel[hit_idx] <= 1'b0;
            end else begin
              state <= ST_IDLE;
              out_valid <= 1'b1;
              out_msg <= make_out(OUT_ERROR, in_msg.name, in_msg.name_len, CAUSE_UNKNOWN);
            end
          end
          OP_SELECT: begin
            if (!hit) begin
              state <= ST_IDLE;
              out_valid <= 1'b1;
              out_msg <= make_out(OUT_ERROR, in_msg.name, in_msg.name_len, CAUSE_UNKNOWN);
            end else if (slot_sel[hit_idx]) begin
              slot_sel <= slot_sel;
            end else if (slot_bad[hit_idx]) begin
              state <= ST_IDLE;
              out_valid <= 1'b1;
              out_msg <= make_out(OUT_ERROR, in_msg.name, in_msg.name_len, CAUSE_CONTENT);
            end else if (sel_load + 16'(slot_cnt[hit_idx]) > 16'(CAPACITY)) begin
              state <= ST_IDLE;
              out_valid <= 1'b1;
              out_msg <= make_out(OUT_ERROR, in_msg.name, in_msg.name_len,
                                  CAPACITY_UNAVAILABLE_CAUSE);
            end else begin
              slot_sel[hit_idx] <= 1'b1;
            end
          end
          OP_DESELECT: begin
            if (hit && slot_sel[hit_idx]) begin
              slot_sel[hit_idx] <= 1'b0;
            end else begin
              state <= ST_IDLE;
              out_valid <= 1'b1;
              out_msg <= make_out(OUT_ERROR, in_msg.name, in_msg.name_len, CAUSE_UNKNOWN);
            end
          end
          OP_ERROR: begin
            state <= ST_IDLE;
          end
          OP_RECONFIG: begin
            slot_sel <= '0;
          end
          default: begin
            state <= state;
          end
        endcase
      end else if ((state == ST_TX) && (!out_valid || out_ready)) begin
        out_valid <= 1'b1;
        if (tx_idx == slot_cnt[tx_slot]) begin
          state <= ST_IDLE;
          out_msg <= make_out(OUT_CLOSE, slot_name[tx_slot], slot_nlen[tx_slot], '0);
        end else begin
          out_msg <= make_out(OUT_RECORD, slot_name[tx_slot], slot_nlen[tx_slot], '0);
          out_msg.group <= grp_mem[mem_addr(tx_slot, tx_idx)];
          out_msg.group_len <= grp_len[mem_addr(tx_slot, tx_idx)];
          tx_idx <= tx_idx + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // input flow control
  // ----------------------------------------
  // drop for a cycle after each message; wait while an answer stands
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      in_ready <= 1'b0;
    end else if (ce) begin
      if (acc) begin
        in_ready <= 1'b0;
      end else begin
        in_ready <= (state != ST_TX) && (!out_valid || out_ready);
      end
    end
  end

  // ----------------------------------------
  // broadcast of selected files
  // ----------------------------------------
  // round robin over stores; repetition is the endless walk itself
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bc_valid <= 1'b0;
      bc_group <= '0;
      bc_group_len <= '0;
      bc_slot <= '0;
      bc_rec <= '0;
    end else if (ce) begin
      if (!bc_valid || bc_ready) begin
        bc_valid <= 1'b0;
        if (slot_used[bc_slot] && slot_sel[bc_slot] && (bc_rec < slot_cnt[bc_slot])) begin
          bc_valid <= 1'b1;
          bc_group <= grp_mem[mem_addr(bc_slot, bc_rec)];
          bc_group_len <= grp_len[mem_addr(bc_slot, bc_rec)];
          bc_rec <= bc_rec + 1'b1;
        end else begin // unselected stores skipped
          bc_rec <= '0;
          bc_slot <= (int'(bc_slot) == SLOTS - 1) ? '0 : bc_slot + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_take(igf_op_type o);
    acc && (in_msg.op == o);
  endsequence

  sequence s_err(logic [CAUSE_W-1:0] c);
    out_valid && (out_msg.kind == OUT_ERROR) && (out_msg.cause == c);
  endsequence

  AST_REQ_ANSWER: assert property (s_take(OP_CONTENT_REQUEST) |=>
    (out_valid && out_msg.kind == OUT_OPEN && state == ST_TX) or s_err(CAUSE_UNKNOWN))
    else $error("content request not answered");
  AST_DEL_GONE: assert property ((s_take(OP_DELETE) and hit) |=>
    !slot_used[$past(hit_idx)] && !slot_sel[$past(hit_idx)])
    else $error("deleted file still present");
  AST_DEL_UNKNOWN: assert property ((s_take(OP_DELETE) and !hit) |=> s_err(CAUSE_UNKNOWN))
    else $error("delete of unknown name not reported");
  AST_SEL_SAME: assert property ((s_take(OP_SELECT) and (hit && slot_sel[hit_idx]))
    |=> !out_valid && $stable(slot_sel))
    else $error("reselect had an effect");
  AST_SEL_UNKNOWN: assert property ((s_take(OP_SELECT) and !hit) |=> s_err(CAUSE_UNKNOWN))
    else $error("select of missing file not reported");
  AST_DES_UNKNOWN: assert property ((s_take(OP_DESELECT) and !(hit && slot_sel[hit_idx]))
    |=> s_err(CAUSE_UNKNOWN))
    else $error("deselect of unselected file not reported");
  AST_ABORT: assert property ((s_take(OP_ERROR) and (state == ST_RX))
    |=> (state == ST_IDLE) && $stable(slot_used))
    else $error("error did not abort session");
  AST_FULL: assert property ((s_take(OP_SESSION_OPEN) and ((state != ST_RX) && !hit
    && !free_any)) |=> s_err(NO_FREE_STORE_CAUSE))
    else $error("open with stores full not refused");
  AST_EARLY_CLOSE: assert property ((s_take(OP_SESSION_CLOSE) and ((state == ST_RX)
    && (rx_idx != rx_cnt))) |=> s_err(WRONG_RECORD_COUNT_CAUSE) ##0 (state == ST_IDLE))
    else $error("early close not reported");

endmodule

// >>> igf_pkg.sv
package igf_pkg;

  // ----------------------------------------
  // field sizes
  // ----------------------------------------
  localparam int unsigned NAME_CHARS = 16;            // longest file name
  localparam int unsigned NAME_W = NAME_CHARS * 8;    // ascii, char 0 in low byte
  localparam int unsigned LEN_W = 5;                  // name length 0..16
  localparam int unsigned CNT_W = 7;                  // record count 0..99
  localparam int unsigned MIN_RECORDS = 1;            // least records per file
  localparam int unsigned GROUP_MIN_BYTES = 4;        // 8 hex characters
  localparam int unsigned GROUP_MAX_BYTES = 30;       // 60 hex characters
  localparam int unsigned GROUP_W = GROUP_MAX_BYTES * 8;
  localparam int unsigned BLEN_W = 5;                 // group length in bytes
  localparam int unsigned CAUSE_W = 7 * 8;            // seven ascii characters

  // ----------------------------------------
  // module defaults
  // ----------------------------------------
  localparam int unsigned DEF_SLOTS = 4;              // file stores
  localparam int unsigned DEF_RECORDS = 99;           // records per store
  localparam int unsigned DEF_CAPACITY = 64;          // groups on air at once

  // ----------------------------------------
  // error causes, ascii, first char in top byte
  // ----------------------------------------
  localparam logic [CAUSE_W-1:0] CAUSE_UNKNOWN = 56'h55_4e_4b_4e_4f_57_4e;
  localparam logic [CAUSE_W-1:0] CAUSE_USED = 56'h55_53_45_44_20_20_20;
  localparam logic [CAUSE_W-1:0] CAUSE_CONTENT = 56'h43_4f_4e_54_45_4e_54;
  localparam logic [CAUSE_W-1:0] WRONG_RECORD_COUNT_CAUSE = 56'h4e_52_45_43_4f_52_44;
  localparam logic [CAUSE_W-1:0] NO_FREE_STORE_CAUSE = 56'h4e_4f_53_50_41_43_45;
  localparam logic [CAUSE_W-1:0] CAPACITY_UNAVAILABLE_CAUSE = 56'h46_49_47_43_41_50_20;

  // ----------------------------------------
  // message kinds and states
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_CONTENT_REQUEST = 4'h0,   // file_content_request
    OP_SESSION_OPEN = 4'h1,      // file_session_open
    OP_RECORD = 4'h2,            // file_record_msg
    OP_SESSION_CLOSE = 4'h3,     // file_session_close
    OP_DELETE = 4'h4,            // file_delete_msg
    OP_SELECT = 4'h5,            // file_select_msg
    OP_DESELECT = 4'h6,          // file_deselect_msg
    OP_ERROR = 4'h7,             // file_error_msg from upstream
    OP_RECONFIG = 4'h8           // reconfiguration instant
  } igf_op_type;

  typedef enum logic [1:0] {
    OUT_OPEN = 2'h0,
    OUT_RECORD = 2'h1,
    OUT_CLOSE = 2'h2,
    OUT_ERROR = 2'h3
  } igf_out_kind_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RX = 3'b010,
    ST_TX = 3'b100
  } igf_state_type;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    igf_op_type op;
    logic [NAME_W-1:0] name;
    logic [LEN_W-1:0] name_len;
    logic [CNT_W-1:0] record_count;
    logic [GROUP_W-1:0] group;          // byte 0 (header) in low byte
    logic [BLEN_W-1:0] group_len;
  } igf_msg_type;

  typedef struct packed {
    igf_out_kind_type kind;
    logic [NAME_W-1:0] name;
    logic [LEN_W-1:0] name_len;
    logic [CNT_W-1:0] record_count;
    logic [GROUP_W-1:0] group;
    logic [BLEN_W-1:0] group_len;
    logic [CAUSE_W-1:0] cause;
  } igf_out_type;

endpackage

// >>> igf_name_match.sv
`timescale 1ns/1ps
module igf_name_match
  import igf_pkg::*;
#(
  parameter int unsigned SLOTS = DEF_SLOTS,
  parameter int unsigned IW = 2
) (
  input wire logic [SLOTS-1:0] used,
  input wire logic [NAME_W-1:0] names [SLOTS],
  input wire logic [LEN_W-1:0] lens [SLOTS],
  input wire logic [NAME_W-1:0] key,
  input wire logic [LEN_W-1:0] key_len,
  output logic hit,
  output logic [IW-1:0] hit_idx,
  output logic free_any,
  output logic [IW-1:0] free_idx
);

  // ----------------------------------------
  // exact compare of every store
  // ----------------------------------------
  logic [SLOTS-1:0] eq; // store holds the key name

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_cmp
      assign eq[g] = used[g] && (lens[g] == key_len) && (names[g] == key);
    end
  endgenerate

  // lowest matching store and lowest free store
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    free_any = 1'b0;
    free_idx = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (eq[i]) begin
        hit = 1'b1;
        hit_idx = IW'(i);
      end
      if (!used[i]) begin
        free_any = 1'b1;
        free_idx = IW'(i);
      end
    end
  end

endmodule

// >>> igf_upstream_model.sv
`timescale 1ns/1ps
module igf_upstream_model
  import igf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic in_ready,
  output logic in_valid,
  output igf_msg_type in_msg
);
  // ----------------------------------------
  // upstream message driver
  // ----------------------------------------
  initial begin
    in_valid = 1'b0;
    in_msg = '0;
  end

  // hold the message from a rising edge until the edge that takes it
  task automatic send(input igf_msg_type m);
    @(posedge ref_clk);
    in_valid <= 1'b1;
    in_msg <= m;
    @(negedge ref_clk);
    while (in_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    in_valid <= 1'b0;
    // released bus shows no stale message
    in_msg <= ~m;
  endtask
endmodule

// >>> igf_file_store_tb_top.sv
`timescale 1ns/1ps
module igf_file_store_tb_top;
  import igf_pkg::*;
  // ----------------------------------------
  // shortened limits and bench signals
  // ----------------------------------------
  localparam int unsigned RECS = 3;  // record count limit
  localparam int unsigned CAP = 4;   // groups on air
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic out_ready = 1'b1;
  logic bc_ready = 1'b1;
  logic in_valid, in_ready, out_valid, bc_valid;
  igf_msg_type in_msg;
  igf_out_type out_msg, got;
  logic [GROUP_W-1:0] bc_group, g;
  logic [BLEN_W-1:0] bc_group_len;
  logic [DEF_SLOTS-1:0] slot_sel;
  int failures = 0;
  int n_compared = 0;

  always #4 ref_clk = ~ref_clk;

  igf_file_store #(.SLOTS(DEF_SLOTS), .RECORDS(RECS), .CAPACITY(CAP)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .in_valid(in_valid), .in_msg(in_msg),
    .in_ready(in_ready), .out_valid(out_valid), .out_msg(out_msg), .out_ready(out_ready),
    .bc_valid(bc_valid), .bc_group(bc_group), .bc_group_len(bc_group_len),
    .bc_ready(bc_ready), .slot_sel(slot_sel));

  igf_upstream_model u_up (.ref_clk(ref_clk), .in_ready(in_ready), .in_valid(in_valid),
    .in_msg(in_msg));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // record payload k, header byte lowest
  function automatic logic [GROUP_W-1:0] grp(input int k);
    grp = GROUP_W'({8'h5a, 8'(k), 8'h3c, 8'h11});
  endfunction

  function automatic igf_msg_type mk(input igf_op_type op, input logic [15:0] nm,
      input logic [CNT_W-1:0] cnt = '0, input logic [BLEN_W-1:0] gl = '0, input int k = 0);
    mk = '0;
    mk.op = op;
    mk.name = NAME_W'(nm);
    mk.name_len = (nm[15:8] != 8'h00) ? 5'h2 : 5'h1;
    mk.record_count = cnt;
    mk.group = grp(k);
    mk.group_len = gl;
  endfunction

  // wait for an answer, copy it, let the next edge consume it
  task automatic get_out();
    @(negedge ref_clk);
    for (int n = 0; n < 40 && out_valid !== 1'b1; n++) @(negedge ref_clk);
    check(out_valid, 1'b1);
    got = out_msg;
    @(posedge ref_clk);
  endtask

  task automatic req_err(input igf_msg_type m, input logic [CAUSE_W-1:0] c);
    u_up.send(m);
    get_out();
    check(got.kind, OUT_ERROR);
    check(got.cause, c);
  endtask

  task automatic quiet();
    repeat (4) @(negedge ref_clk) check(out_valid, 1'b0);
  endtask

  task automatic store(input logic [15:0] nm, input int cnt, input logic [BLEN_W-1:0] gl);
    u_up.send(mk(OP_SESSION_OPEN, nm, CNT_W'(cnt)));
    for (int i = 0; i < cnt; i++) u_up.send(mk(OP_RECORD, '0, '0, gl, i));
    u_up.send(mk(OP_SESSION_CLOSE, '0));
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    // first edge applies the reset; release lands on the twelfth edge
    @(posedge ref_clk);
    repeat (11) @(negedge ref_clk) check({in_ready, out_valid, bc_valid, slot_sel}, '0);
    @(posedge ref_clk) rst <= 1'b0;
  endtask

  // store a file, then read it back
  task automatic t_store();
    store(16'h41, 2, 5'h4);
    quiet();
    u_up.send(mk(OP_CONTENT_REQUEST, 16'h41));
    get_out();
    check({got.kind, got.record_count}, {OUT_OPEN, 7'h2});
    for (int i = 0; i < 2; i++) begin
      get_out();
      g = grp(i);
      check({got.kind, got.group_len, got.group[31:0]}, {OUT_RECORD, 5'h4, g[31:0]});
    end
    get_out();
    check(got.kind, OUT_CLOSE);
  endtask

  task automatic t_session();
    req_err(mk(OP_RECORD, '0, '0, 5'h4), WRONG_RECORD_COUNT_CAUSE);
    req_err(mk(OP_SESSION_CLOSE, '0), WRONG_RECORD_COUNT_CAUSE);
    req_err(mk(OP_SESSION_OPEN, 16'h42, 7'h0), WRONG_RECORD_COUNT_CAUSE);
    req_err(mk(OP_SESSION_OPEN, 16'h42, 7'(RECS + 1)), WRONG_RECORD_COUNT_CAUSE);
    req_err(mk(OP_SESSION_OPEN, 16'h41, 7'h1), CAUSE_USED);
    // early close aborts the session
    u_up.send(mk(OP_SESSION_OPEN, 16'h58, 7'h2));
    u_up.send(mk(OP_RECORD, '0, '0, 5'h4));
    req_err(mk(OP_SESSION_CLOSE, '0), WRONG_RECORD_COUNT_CAUSE);
    req_err(mk(OP_CONTENT_REQUEST, 16'h58), CAUSE_UNKNOWN);
    // incoming error drops the open session
    u_up.send(mk(OP_SESSION_OPEN, 16'h59, 7'h1));
    u_up.send(mk(OP_ERROR, 16'h59));
    req_err(mk(OP_RECORD, '0, '0, 5'h4), WRONG_RECORD_COUNT_CAUSE);
    req_err(mk(OP_CONTENT_REQUEST, 16'h59), CAUSE_UNKNOWN);
    req_err(mk(OP_CONTENT_REQUEST, 16'h4141), CAUSE_UNKNOWN);
  endtask

  // low clock enable keeps a standing answer in place
  task automatic t_hold();
    u_up.send(mk(OP_DELETE, 16'h46));
    ce <= 1'b0;
    repeat (3) @(negedge ref_clk) check(out_valid, 1'b1);
    @(posedge ref_clk) ce <= 1'b1;
    get_out();
    check({got.kind, got.cause}, {OUT_ERROR, CAUSE_UNKNOWN});
  endtask

  task automatic t_select();
    u_up.send(mk(OP_SELECT, 16'h41));
    quiet();
    check(slot_sel != '0, 1'b1);
    @(posedge ref_clk) bc_ready <= 1'b0;
    // look only after the launching edge has settled
    @(negedge ref_clk);
    for (int n = 0; n < 40 && bc_valid !== 1'b1; n++) @(negedge ref_clk);
    g = bc_group;
    repeat (3) @(negedge ref_clk) check({bc_valid, bc_group == g}, 2'b11);
    check({g == grp(0) || g == grp(1), bc_group_len}, {1'b1, 5'h4});
    @(posedge ref_clk) bc_ready <= 1'b1;
    u_up.send(mk(OP_SELECT, 16'h41));
    quiet();
    check(slot_sel != '0, 1'b1);
    // unknown name while the consumer stalls
    @(posedge ref_clk) out_ready <= 1'b0;
    u_up.send(mk(OP_SELECT, 16'h51));
    get_out();
    repeat (3) @(negedge ref_clk) check({out_valid, out_msg.cause == CAUSE_UNKNOWN}, 2'b11);
    @(posedge ref_clk) out_ready <= 1'b1;
    req_err(mk(OP_DESELECT, 16'h51), CAUSE_UNKNOWN);
    u_up.send(mk(OP_DESELECT, 16'h41));
    quiet();
    check(slot_sel, '0);
    req_err(mk(OP_DESELECT, 16'h41), CAUSE_UNKNOWN);
  endtask

  task automatic t_more();
    store(16'h42, 1, 5'h2);
    req_err(mk(OP_SELECT, 16'h42), CAUSE_CONTENT);
    store(16'h43, 3, 5'h4);
    u_up.send(mk(OP_SELECT, 16'h41));
    req_err(mk(OP_SELECT, 16'h43), CAPACITY_UNAVAILABLE_CAUSE);
    u_up.send(mk(OP_RECONFIG, '0));
    quiet();
    check(slot_sel, '0);
    store(16'h44, 1, 5'h4);
    req_err(mk(OP_SESSION_OPEN, 16'h45, 7'h1), NO_FREE_STORE_CAUSE);
    u_up.send(mk(OP_SELECT, 16'h41));
    u_up.send(mk(OP_DELETE, 16'h41));
    quiet();
    check(slot_sel, '0);
    req_err(mk(OP_DELETE, 16'h41), CAUSE_UNKNOWN);
    store(16'h45, 1, 5'h4);
    u_up.send(mk(OP_CONTENT_REQUEST, 16'h45));
    get_out();
    check({got.kind, got.record_count}, {OUT_OPEN, 7'h1});
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    t_reset();
    t_store();
    t_session();
    t_hold();
    t_select();
    t_more();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    $display("ERROR at %0t: run did not finish", $time);
    close_out();
  end
endmodule
